// ==== design/phyrx_pkg.sv ====
// Purpose: Shared constants for the receive nibble and strap pin block.
// Assumes: 200 MHz system clock and a 32-bit APB register bus.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package phyrx_pkg;

  // System clock and generated receive clock rates, in hertz.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned RXCLK_100_HZ = 25_000_000;
  localparam int unsigned RXCLK_10_HZ = 2_500_000;

  // Half periods of the receive clock, in system clock cycles.
  localparam int unsigned HALF_100 = CLK_HZ / (2 * RXCLK_100_HZ);
  localparam int unsigned HALF_10 = CLK_HZ / (2 * RXCLK_10_HZ);
  localparam int DIV_W = 8;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STRAP = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Control register fields and reset value.
  localparam int CTRL_SPEED100 = 0;
  localparam int CTRL_RMII = 1;
  localparam int CTRL_SYMBOL = 2;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h1;

  // Strap register fields.
  localparam int STRAP_MODE_LSB = 0;
  localparam int STRAP_IRQSEL = 3;
  localparam int MODE_W = 3;

  // Interrupt status and mask fields.
  localparam int IRQ_FRAME_ERR = 0;
  localparam int IRQ_FRAME_END = 1;
  localparam int IRQ_TX_FAULT = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Status register fields.
  localparam int STAT_IN_FRAME = 0;
  localparam int STAT_FRAME_ERR = 1;
  localparam int STAT_RUN = 2;

  // Strap capture sequence, Gray coded along its only path.
  typedef enum logic [1:0] {
    PHYRX_ST_RESET = 2'h0,
    PHYRX_ST_STRAP = 2'h1,
    PHYRX_ST_RUN = 2'h3
  } phyrx_state_e;

endpackage

// ==== design/phyrx_sync.sv ====
// Purpose: Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level; no bus coherence is promised.
// Notes: Runs through reset so straps are settled when reset is released.
`timescale 1ns/1ps
`default_nettype none
module phyrx_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // No reset: the flops must follow the pins while the chip is held in reset.
  always_ff @(posedge clk) begin
    meta <= din;
    dout <= meta;
  end

endmodule // phyrx_sync
`default_nettype wire

// ==== design/phyrx_pins.sv ====
// Purpose: Receive nibble, receive error and shared interrupt pin logic with strap capture.
// Assumes: The decoder feeds one nibble per receive clock period on src_take.
// Notes: Registers are reached over APB; straps are caught just after reset release.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module phyrx_pins (
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded receive stream from the line decoder.
  input wire logic src_valid,
  input wire logic [3:0] src_nibble,
  input wire logic src_sym_msb,
  input wire logic src_err,
  output logic src_take,
  // Receive data pins, shared with the mode and interrupt select straps.
  input wire logic [3:0] rxd_in,
  output logic [3:0] rxd_out,
  output logic [3:0] rxd_oe,
  // Receive side outputs to the controller.
  output logic rx_nibble_valid,
  output logic rx_fault_flag,
  output logic rx_clk_out,
  // Shared interrupt, transmit error or fifth transmit bit pin.
  input wire logic tx_fault_or_fifth_bit_in,
  output logic tx_fault_or_fifth_bit_out,
  output logic tx_fault_or_fifth_bit_oe,
  // Towards the transmit encoder.
  output logic tx_substitute_h,
  output logic tx_fifth_bit,
  // Captured default mode and interrupt level.
  output logic [2:0] default_mode,
  output logic irq
);

  phyrx_pkg::phyrx_state_e state;
  logic [3:0] rxd_sync;
  logic tx_pin_sync;
  logic irq_pin_select_strap;
  logic [phyrx_pkg::CTRL_W-1:0] ctrl;
  logic [phyrx_pkg::IRQ_W-1:0] irq_status;
  logic [phyrx_pkg::IRQ_W-1:0] irq_mask;
  logic [phyrx_pkg::IRQ_W-1:0] irq_event;
  logic [phyrx_pkg::DIV_W-1:0] div_cnt;
  logic [phyrx_pkg::DIV_W-1:0] div_half;
  logic rx_clk_int;
  logic tick;
  logic running;
  logic speed100;
  logic rmii;
  logic symbol;
  logic in_frame;
  logic frame_err;
  logic tx_fault_input;
  logic irq_out_low;
  logic apb_setup;
  logic apb_write;
  logic addr_ok;
  logic [31:0] next_prdata;

  assign speed100 = ctrl[phyrx_pkg::CTRL_SPEED100];
  assign rmii = ctrl[phyrx_pkg::CTRL_RMII];
  assign symbol = ctrl[phyrx_pkg::CTRL_SYMBOL];
  assign running = (state == phyrx_pkg::PHYRX_ST_RUN);

  phyrx_sync #(
    .WIDTH(4)
  ) u_rxd_sync (
    .clk(clk),
    .din(rxd_in),
    .dout(rxd_sync)
  );

  phyrx_sync #(
    .WIDTH(1)
  ) u_tx_sync (
    .clk(clk),
    .din(tx_fault_or_fifth_bit_in),
    .dout(tx_pin_sync)
  );

  // The pins are only sampled once the synchronised strap levels are
  // known to be taken from the released chip, one cycle after release.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= phyrx_pkg::PHYRX_ST_RESET;
    end else begin
      unique case (state)
        phyrx_pkg::PHYRX_ST_RESET: begin
          state <= phyrx_pkg::PHYRX_ST_STRAP;
        end
        phyrx_pkg::PHYRX_ST_STRAP: begin
          state <= phyrx_pkg::PHYRX_ST_RUN;
        end
        phyrx_pkg::PHYRX_ST_RUN: begin
          state <= phyrx_pkg::PHYRX_ST_RUN;
        end
        default: begin
          state <= phyrx_pkg::PHYRX_ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      default_mode <= 3'h0;
    end else if (state == phyrx_pkg::PHYRX_ST_STRAP) begin
      default_mode <= rxd_sync[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_pin_select_strap <= 1'h1;
    end else if (state == phyrx_pkg::PHYRX_ST_STRAP) begin
      irq_pin_select_strap <= rxd_sync[3];
    end
  end

  assign div_half = speed100 ? phyrx_pkg::DIV_W'(phyrx_pkg::HALF_100)
                             : phyrx_pkg::DIV_W'(phyrx_pkg::HALF_10);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
      rx_clk_int <= 1'h0;
    end else if (div_cnt >= div_half - 8'h01) begin
      div_cnt <= 8'h00;
      rx_clk_int <= ~rx_clk_int;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // New data is launched on the falling receive clock edge so that it is
  // centred on the rising edge at which the controller samples it.
  assign tick = running && rx_clk_int && (div_cnt >= div_half - 8'h01);
  assign src_take = tick;

  // clock unused in reduced pin mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_clk_out <= 1'h0;
    end else begin
      rx_clk_out <= rx_clk_int && !rmii;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxd_out <= 4'h0;
      rx_nibble_valid <= 1'h0;
    end else if (tick) begin
      rx_nibble_valid <= src_valid;
      rxd_out <= src_valid ? src_nibble : 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxd_oe <= 4'h0;
    end else begin
      rxd_oe <= running ? (rmii ? 4'h3 : 4'hF) : 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_frame <= 1'h0;
    end else if (tick) begin
      in_frame <= src_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_err <= 1'h0;
    end else if (tick) begin
      if (!src_valid) begin
        frame_err <= 1'h0;
      end else if (src_err) begin
        frame_err <= 1'h1;
      end
    end
  end

  // nothing reads the error pin back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_fault_flag <= 1'h0;
    end else if (tick) begin
      if (symbol) begin
        rx_fault_flag <= src_valid && src_sym_msb;
      end else begin
        rx_fault_flag <= src_valid && (src_err || (frame_err && in_frame));
      end
    end
  end

  assign tx_fault_input = running && !irq_pin_select_strap && tx_pin_sync;

  // error code only at 100 Mb/s
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_substitute_h <= 1'h0;
      tx_fifth_bit <= 1'h0;
    end else begin
      tx_substitute_h <= tx_fault_input && speed100 && !symbol && !rmii;
      tx_fifth_bit <= tx_fault_input && symbol && !rmii;
    end
  end

  // Events for the interrupt status register.
  assign irq_event[phyrx_pkg::IRQ_FRAME_ERR] = tick && src_valid && src_err && !symbol;
  assign irq_event[phyrx_pkg::IRQ_FRAME_END] = tick && in_frame && !src_valid;
  assign irq_event[phyrx_pkg::IRQ_TX_FAULT] = tx_substitute_h;

  // APB decode; the slave answers in the first access cycle.
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && !pslverr;
  assign pready = 1'h1;

  always_comb begin
    addr_ok = 1'h1;
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      phyrx_pkg::ADDR_CTRL: begin
        next_prdata[phyrx_pkg::CTRL_W-1:0] = ctrl;
      end
      phyrx_pkg::ADDR_STRAP: begin
        next_prdata[phyrx_pkg::STRAP_MODE_LSB +: phyrx_pkg::MODE_W] = default_mode;
        next_prdata[phyrx_pkg::STRAP_IRQSEL] = irq_pin_select_strap;
      end
      phyrx_pkg::ADDR_IRQ_STATUS: begin
        next_prdata[phyrx_pkg::IRQ_W-1:0] = irq_status;
      end
      phyrx_pkg::ADDR_IRQ_MASK: begin
        next_prdata[phyrx_pkg::IRQ_W-1:0] = irq_mask;
      end
      phyrx_pkg::ADDR_STATUS: begin
        next_prdata[phyrx_pkg::STAT_IN_FRAME] = in_frame;
        next_prdata[phyrx_pkg::STAT_FRAME_ERR] = frame_err;
        next_prdata[phyrx_pkg::STAT_RUN] = running;
      end
      default: begin
        addr_ok = 1'h0;
      end
    endcase
  end

  // Read data and error are caught in the setup cycle so both come from flops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'h0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !addr_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= phyrx_pkg::CTRL_RESET;
    end else if (apb_write && paddr == phyrx_pkg::ADDR_CTRL) begin
      ctrl <= pwdata[phyrx_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask <= phyrx_pkg::IRQ_MASK_RESET;
    end else if (apb_write && paddr == phyrx_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= pwdata[phyrx_pkg::IRQ_W-1:0];
    end
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status <= 3'h0;
    end else if (apb_write && paddr == phyrx_pkg::ADDR_IRQ_STATUS) begin
      irq_status <= (irq_status & ~pwdata[phyrx_pkg::IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // shared pin as low interrupt
  // The pin is open drain in this role: it only ever pulls low, and the
  // board pull-up gives the idle high level.
  assign irq_out_low = ~irq;
  assign tx_fault_or_fifth_bit_out = 1'h0;
  assign tx_fault_or_fifth_bit_oe = running && irq_pin_select_strap && !irq_out_low;

endmodule // phyrx_pins
`default_nettype wire

// ==== verification/phyrx_sva.sv ====
// Purpose: Port checker for the receive pin block.
// Assumes: Control writes are seen on the APB port.
// Notes: A mirror of the control register qualifies the mode checks.
`timescale 1ns/1ps
`default_nettype none
module phyrx_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic src_valid,
  input wire logic [3:0] src_nibble,
  input wire logic src_sym_msb,
  input wire logic src_err,
  input wire logic src_take,
  input wire logic [3:0] rxd_in,
  input wire logic [3:0] rxd_out,
  input wire logic [3:0] rxd_oe,
  input wire logic rx_fault_flag,
  input wire logic rx_nibble_valid,
  input wire logic rx_clk_out,
  input wire logic tx_fault_or_fifth_bit_oe,
  input wire logic [2:0] default_mode,
  input wire logic irq
);
  logic [2:0] ctrl;
  logic [2:0] runc;
  logic sel;
  logic [2:0] hi_cnt;
  logic [2:0] fast_run;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Bit 1 is reduced pin mode, bit 2 symbol mode, bit 0 the fast rate.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= phyrx_pkg::CTRL_RESET;
      runc <= 3'h0;
      sel <= rxd_in[3];
    end else begin
      if (runc != 3'h7) begin
        runc <= runc + 3'h1;
      end
      if (psel && penable && pwrite && paddr == phyrx_pkg::ADDR_CTRL) begin
        ctrl <= pwdata[2:0];
      end
    end
  end
  // A rate change bends the current half period, so only halves inside a long
  // stretch of fast, full pin mode are measured.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_cnt <= 3'h0;
      fast_run <= 3'h0;
    end else begin
      if (!rx_clk_out) begin
        hi_cnt <= 3'h0;
      end else if (hi_cnt != 3'h7) begin
        hi_cnt <= hi_cnt + 3'h1;
      end
      if (!ctrl[0] || ctrl[1]) begin
        fast_run <= 3'h0;
      end else if (fast_run != 3'h7) begin
        fast_run <= fast_run + 3'h1;
      end
    end
  end
  AST_NIBBLE_BITS: assert property (src_take && src_valid && !ctrl[1] |=>
    rxd_out == $past(src_nibble)) else $error("nibble bits misplaced");
  AST_VALID_MARK: assert property (src_take |=> rx_nibble_valid == $past(src_valid))
    else $error("valid does not follow nibble");
  AST_MODE_HELD: assert property (runc == 3'h7 |-> $stable(default_mode))
    else $error("mode strap changed");
  AST_DRIVE_LATE: assert property (rxd_oe != 4'h0 |-> runc >= 3'h2)
    else $error("pins driven during strap capture");
  AST_RMII_LINES: assert property (ctrl[1] && $past(ctrl[1]) |->
    rxd_oe[3:2] == 2'h0 && !rx_clk_out) else $error("upper lines or clock active");
  AST_FRAME_ERR: assert property (src_take && src_valid && src_err && !ctrl[2] |=>
    rx_fault_flag) else $error("error not flagged");
  AST_SYMBOL_MSB: assert property (src_take && src_valid && ctrl[2] |=>
    rx_fault_flag == $past(src_sym_msb)) else $error("symbol top bit wrong");
  AST_IRQ_PIN: assert property (sel && $rose(irq) |-> ##[0:2] tx_fault_or_fifth_bit_oe)
    else $error("interrupt not on shared pin");
  AST_INPUT_MODE: assert property (!sel |-> !tx_fault_or_fifth_bit_oe)
    else $error("shared pin driven as input");
  AST_CLK_HALF: assert property ($fell(rx_clk_out) && fast_run == 3'h7 |->
    hi_cnt == 3'h4) else $error("fast clock half wrong");
endmodule // phyrx_sva
bind phyrx_pins phyrx_sva u_phyrx_sva (.clk, .rst_n, .paddr, .psel, .penable, .pwrite,
  .pwdata, .src_valid, .src_nibble, .src_sym_msb, .src_err, .src_take, .rxd_in, .rxd_out,
  .rxd_oe, .rx_fault_flag, .rx_nibble_valid, .rx_clk_out, .tx_fault_or_fifth_bit_oe,
  .default_mode, .irq);
`default_nettype wire

// ==== verification/phyrx_mac_model.sv ====
// Purpose: Controller side of the receive pins, with strap and pull resolution.
// Assumes: Strap resistors stay fitted; the shared pin has a pull-up.
// Notes: Undriven lines show the strap pull, never the last driven value.
`timescale 1ns/1ps
`default_nettype none
module phyrx_mac_model (
  input wire logic [3:0] strap,
  input wire logic [3:0] rxd_out,
  input wire logic [3:0] rxd_oe,
  input wire logic irq_pin_oe,
  input wire logic tx_fault_en,
  input wire logic tx_fault_drive,
  output logic [3:0] rxd_pin,
  output logic shared_pin
);
  // receive error untouched
  // The controller never drives the receive error line; the bench checks it in reduced pin mode too.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rxd_pin[i] = rxd_oe[i] ? rxd_out[i] : strap[i];
    end
    // The controller drives the shared pin only in transmit error mode; else the pull-up wins unless the block pulls it low as interrupt.
    shared_pin = irq_pin_oe ? 1'b0 : (tx_fault_en ? tx_fault_drive : 1'b1);
  end
endmodule // phyrx_mac_model
`default_nettype wire

// ==== verification/phyrx_pins_test.sv ====
// Purpose: Self-checking bench for the receive pin block.
// Assumes: The bench plays the line decoder and the APB master.
// Notes: Stream results are noted in a queue and compared by a monitor.
`timescale 1ns/1ps
`default_nettype none
module phyrx_pins_test;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, r, rv;
  logic src_valid = 1'b0, src_sym_msb = 1'b0, src_err = 1'b0, run = 1'b0, took = 1'b0;
  logic [3:0] src_nibble = 4'h0, strap = 4'hD, rxd_out, rxd_oe, rxd_pin;
  logic tx_drive = 1'b0, acc = 1'b0, saw = 1'b0, f, se, pready, pslverr, src_take, shared_pin;
  logic rx_nibble_valid, rx_fault_flag, rx_clk_out, tx_oe, subst, fifth, irq;
  logic [31:0] prdata;
  logic [2:0] ctrl = 3'h1, default_mode;
  logic [7:0] e;
  logic [7:0] q[$];
  int takes = 0, mismatches = 0, check_count = 0, cyc = 0, seed = 32'h5DEE08F8;
  phyrx_pins u_phyrx_pins (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .src_valid, .src_nibble, .src_sym_msb, .src_err, .src_take,
    .rxd_in(rxd_pin), .rxd_out, .rxd_oe, .rx_nibble_valid, .rx_fault_flag, .rx_clk_out,
    .tx_fault_or_fifth_bit_in(shared_pin), .tx_fault_or_fifth_bit_out(),
    .tx_fault_or_fifth_bit_oe(tx_oe), .tx_substitute_h(subst), .tx_fifth_bit(fifth),
    .default_mode, .irq);
  phyrx_mac_model u_phyrx_mac_model (.strap, .rxd_out, .rxd_oe, .irq_pin_oe(tx_oe),
    .tx_fault_en(!strap[3]), .tx_fault_drive(tx_drive), .rxd_pin, .shared_pin);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a == phyrx_pkg::ADDR_CTRL) ctrl <= d[2:0];
  endtask
  task automatic stream(input int n);
    int t;
    t = takes + n;
    run <= 1'b1;
    while (takes < t) @(posedge clk);
    run <= 1'b0;
    repeat (200) @(posedge clk);
  endtask
  task automatic do_reset(input logic [3:0] s);
    strap <= s;
    rst_n <= 1'b0;
    ctrl = 3'h1;
    q.delete();
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // The decoder side notes each expected nibble when the block takes it.
  always @(posedge clk) begin
    took <= src_take === 1'b1;
    if (src_take === 1'b1) begin
      takes <= takes + 1;
      f = ctrl[2] ? src_sym_msb : (src_err | acc);
      q.push_back({ctrl[1], 1'b0, src_valid, f, src_nibble});
      if (src_valid && src_err && !ctrl[2]) saw <= 1'b1;
      acc = src_valid & (acc | src_err);
      rv = $random(seed);
      src_valid <= run & (rv[2:0] != 3'h0);
      src_err <= rv[7:4] == 4'h0;
      {src_sym_msb, src_nibble} <= rv[12:8];
    end
  end
  always @(posedge clk) begin
    if (took && q.size() > 0) begin
      e = q.pop_front();
      chk("valid", rx_nibble_valid, e[5]);
      if (e[5]) begin
        chk("data", e[7] ? rxd_pin[1:0] : rxd_pin, e[7] ? e[1:0] : e[3:0]);
        chk("fault", rx_fault_flag, e[4]);
      end
      if (e[7]) chk("upper_oe", rxd_oe[3:2], 2'h0);
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    do_reset(4'hD);
    chk("mode", default_mode, 3'h5);
    apb(1'b0, phyrx_pkg::ADDR_STRAP, 32'h0);
    chk("strap", r, 32'hD);
    chk("drive", rxd_oe, 4'hF);
    apb(1'b0, phyrx_pkg::ADDR_STATUS, 32'h0);
    chk("status", r, 32'h4);
    stream(200);
    apb(1'b1, phyrx_pkg::ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq_pin", {irq, shared_pin}, {saw, ~saw});
    apb(1'b1, phyrx_pkg::ADDR_IRQ_STATUS, 32'h7);
    apb(1'b0, phyrx_pkg::ADDR_IRQ_STATUS, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq_clear", {r[2:0], irq, shared_pin}, 5'h01);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", {31'h0, se}, 32'h1);
    chk("unmapped_data", r, 32'h0);
    apb(1'b1, phyrx_pkg::ADDR_CTRL, 32'h5);
    stream(100);
    apb(1'b1, phyrx_pkg::ADDR_CTRL, 32'h3);
    stream(100);
    do_reset(4'h2);
    chk("mode2", {default_mode, tx_oe, subst}, 5'h08);
    tx_drive <= 1'b1;
    repeat (6) @(posedge clk);
    chk("subst", subst, 1'b1);
    apb(1'b1, phyrx_pkg::ADDR_CTRL, 32'h5);
    repeat (6) @(posedge clk);
    chk("fifth", fifth, 1'b1);
    apb(1'b1, phyrx_pkg::ADDR_CTRL, 32'h0);
    repeat (6) @(posedge clk);
    chk("subst_slow", subst, 1'b0);
    stream(20);
    end_sim();
  end
endmodule // phyrx_pins_test
`default_nettype wire
